// ==== rtl/power_save_clock_gating.sv ====
/*
  Idle/Sleep entry and wake-up, doze divider of the CPU clock enable,
  auxiliary clock source control and per-module clock disable.
  assumes CPU, watchdog and interrupt controller run on core_clk.
*/
// Function
// [R1] auxiliary PLL multiplies its reference by a fixed sixteen
// [R2] auxiliary PLL reference is primary oscillator or fast RC
// [R3] software sets the auxiliary clock to 120 MHz for PWM
// [R4] fine 1.04 ns PWM resolution only from the PLL, else 8 ns
// [R5] software keeps primary PLL at 30 MIPS when feeding aux clock
// [R6] Idle gates the CPU clock and stops execution
// [R7] Idle entry clears the watchdog count
// [R8] Idle keeps system clock running; modules clocked unless disabled
// [R9] low-power RC runs while watchdog or clock monitor is enabled
// [R10] Idle ends on enabled interrupt, reset or watchdog time-out
// [R11] after wake-up execution resumes two to four cycles later
// [R12] interrupt during power-save entry is deferred then wakes device
// [R13] doze keeps system and peripheral clocks, slows only the CPU
// [R14] doze CPU enable stays aligned to the peripheral clock
// [R15] doze active only while the doze enable bit is set
// [R16] three-bit ratio selects 1:1 to 1:128, reset 1:1
// [R17] recover-on-interrupt bit makes an interrupt end doze
// [R18] ratio code n divides by two to the power n
// [R19] module disable acts one instruction cycle after it changes
`timescale 1ns/1ps
`default_nettype none

module power_save_clock_gating (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu core
  input  wire logic        pwrSaveReq,
  input  wire logic        pwrSaveSleep,
  input  wire logic        irqPending,
  output logic             cpuClkEn,
  output logic             cpuExecEn,
  output logic             resumeIsr,
  // watchdog and clock monitor
  input  wire logic        wdtEnable,
  input  wire logic        clkMonEnable,
  input  wire logic        wdtTimeout,
  output logic             wdtClear,
  // clock sources and peripheral clocks
  output logic             sysClkRun,
  output logic             lowPowerRcRun,
  output logic [7:0]       periphClkEn,
  output logic             auxRefFastRc,
  output logic             auxPllSel,
  output logic [7:0]       auxMult,
  output logic [13:0]      pwmResPs
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------------------------------------------------------
  // registers and decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_RUN, S_ENTER, S_IDLE, S_SLEEP, S_WAKE
  } pstate_t;

  pstate_t                    state;
  pstate_t                    next_state;
  clk_pwr_pkg::clock_divisor_register_t       clock_divisor_register;
  clk_pwr_pkg::auxcfg_t       auxcfg;
  logic [7:0]                 modDis;
  logic [7:0]                 modDisDly;
  logic [6:0]                 divCnt;
  logic [2:0]                 wakeCnt;
  logic                       modeSleep;
  logic                       deferIrq;

  wire        wrEn    = psel & penable & pwrite;
  wire        setupRd = psel & ~penable & ~pwrite;
  wire        selDiv  = paddr == clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_OFF;
  wire        selAux  = paddr == clk_pwr_pkg::AUXCFG_OFF;
  wire        selDis  = paddr == clk_pwr_pkg::MODDIS_OFF;
  wire        selStat = paddr == clk_pwr_pkg::STATUS_OFF;
  wire        mapped  = selDiv | selAux | selDis | selStat;
  wire        wrDiv   = wrEn & selDiv;

  // doze ratio mask: code n gives a divide by 2**n
  wire [6:0]  ratioMask = 7'((8'h01 << clock_divisor_register.ratio) - 8'h01); // [R16] [R18]
  wire        dozeActive = clock_divisor_register.doze_enable_bit & (state == S_RUN); // [R15]
  wire        recoverHit = clock_divisor_register.recover & clock_divisor_register.doze_enable_bit &
                           irqPending; // [R17]
  wire        wakeEvt = irqPending | wdtTimeout | deferIrq; // [R10] [R12]

  wire [15:0] divWord = {clock_divisor_register.recover, clock_divisor_register.ratio, clock_divisor_register.doze_enable_bit, 11'h000};
  wire [15:0] statWord = {11'h000, auxcfg.pllSel,
                          dozeActive, state == S_SLEEP,
                          state == S_IDLE, cpuExecEn};

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // register writes and read data
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      clock_divisor_register <= clk_pwr_pkg::clock_divisor_register_t'(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_RST[15:11]);
      auxcfg <= clk_pwr_pkg::AUXCFG_RST;
      modDis <= clk_pwr_pkg::MODDIS_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (wrDiv) begin
        clock_divisor_register <= pwdata[clk_pwr_pkg::RECOVER_BIT:clk_pwr_pkg::DOZE_ENABLE_BIT_BIT];
      end
      if (recoverHit && state == S_RUN) begin
        clock_divisor_register.doze_enable_bit <= 1'b0; // [R17]
      end
      if (wrEn && selAux) begin
        auxcfg.refFastRc <= pwdata[clk_pwr_pkg::AUX_REF_BIT]; // [R2]
        auxcfg.pllSel    <= pwdata[clk_pwr_pkg::AUX_PLL_BIT];
      end
      if (wrEn && selDis) begin
        modDis <= pwdata[7:0];
      end
      if (setupRd) begin
        prdata <= selDiv  ? {16'h0000, divWord} :
                  selAux  ? {30'h0, auxcfg} :
                  selDis  ? {24'h000000, modDis} :
                  selStat ? {16'h0000, statWord} : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // power-save state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (pwrSaveReq) begin
          next_state = S_ENTER;
        end
      end
      S_ENTER: begin
        next_state = modeSleep ? S_SLEEP : S_IDLE; // [R12]
      end
      S_IDLE: begin
        if (wakeEvt) begin
          next_state = S_WAKE; // [R10]
        end
      end
      S_SLEEP: begin
        if (irqPending || deferIrq) begin
          next_state = S_WAKE; // [R12]
        end
      end
      S_WAKE: begin
        if (wakeCnt == clk_pwr_pkg::WAKE_CYCLES - 3'h1) begin
          next_state = S_RUN; // [R11]
        end
      end
      default: begin
        next_state = S_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      state     <= S_RUN;
      modeSleep <= 1'b0;
      deferIrq  <= 1'b0;
      wakeCnt   <= 3'h0;
      wdtClear  <= 1'b0;
      resumeIsr <= 1'b0;
    end else begin
      state    <= next_state;
      wdtClear <= state == S_ENTER && !modeSleep; // [R7]
      if (state == S_RUN && pwrSaveReq) begin
        modeSleep <= pwrSaveSleep;
      end
      if ((state == S_RUN && pwrSaveReq) || state == S_ENTER) begin
        deferIrq <= deferIrq | irqPending; // [R12]
      end else if (state == S_WAKE) begin
        deferIrq <= 1'b0;
      end
      wakeCnt <= (state == S_WAKE) ? wakeCnt + 3'h1 : 3'h0;
      if (next_state == S_WAKE && state != S_WAKE) begin
        resumeIsr <= irqPending | deferIrq;
      end else if (state == S_RUN && pwrSaveReq) begin
        resumeIsr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // doze divider and module clock disable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      divCnt    <= 7'h00;
      modDisDly <= clk_pwr_pkg::MODDIS_RST;
    end else begin
      // counts on the same edges the peripherals see
      divCnt    <= (dozeActive && divCnt != ratioMask) ?
                   divCnt + 7'h01 : 7'h00; // [R14]
      modDisDly <= modDis; // [R19]
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cpuClkEn  = (state == S_WAKE) ||
                     (state == S_RUN && divCnt == 7'h00); // [R6] [R13]
  assign cpuExecEn = state == S_RUN;
  assign sysClkRun = state != S_SLEEP; // [R8]
  assign lowPowerRcRun = wdtEnable | clkMonEnable; // [R9]
  assign periphClkEn = sysClkRun ? ~modDisDly : 8'h00; // [R8] [R13]
  assign auxRefFastRc = auxcfg.refFastRc; // [R2]
  assign auxPllSel   = auxcfg.pllSel;
  assign auxMult     = clk_pwr_pkg::AUX_MULT; // [R1]
  assign pwmResPs    = auxcfg.pllSel ? clk_pwr_pkg::PWM_RES_FINE_PS :
                       clk_pwr_pkg::PWM_RES_COARSE_PS; // [R4]

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync);

  cpu_gated_a: assert property ( // [R6]
    state == S_IDLE |-> !cpuClkEn && !cpuExecEn)
    else $error("cpu clock not gated in idle");

  wdt_clear_a: assert property ( // [R7]
    state == S_ENTER && !modeSleep |=> wdtClear && state == S_IDLE)
    else $error("watchdog not cleared on idle entry");

  idle_clocks_a: assert property ( // [R8]
    state == S_IDLE |-> sysClkRun && periphClkEn == ~modDisDly)
    else $error("clocks stopped in idle");

  slow_osc_on_a: assert property ( // [R9]
    (wdtEnable || clkMonEnable) |-> lowPowerRcRun)
    else $error("low-power oscillator stopped");

  idle_wake_a: assert property ( // [R10]
    state == S_IDLE && (irqPending || wdtTimeout) |=> state == S_WAKE)
    else $error("idle did not end on wake event");

  resume_time_a: assert property ( // [R11]
    state != S_WAKE ##1 state == S_WAKE |-> cpuClkEn ##[2:4] cpuExecEn)
    else $error("execution not resumed in two to four cycles");

  defer_irq_a: assert property ( // [R12]
    state == S_ENTER && irqPending
      |=> state inside {S_IDLE, S_SLEEP} ##1 state == S_WAKE)
    else $error("deferred interrupt lost");

  doze_ratio_a: assert property ( // [R16]
    dozeActive && cpuClkEn && ratioMask != 7'h00 && $stable(clock_divisor_register)
      |=> !cpuClkEn)
    else $error("doze divide wrong");

  doze_off_a: assert property ( // [R15]
    !clock_divisor_register.doze_enable_bit |=> cpuClkEn || state != S_RUN)
    else $error("cpu clock divided with doze off");

  doze_periph_a: assert property ( // [R13]
    dozeActive |-> sysClkRun && periphClkEn == ~modDisDly)
    else $error("peripheral clocks slowed in doze");

  recover_exit_a: assert property ( // [R17]
    state == S_RUN && recoverHit
      |=> !clock_divisor_register.doze_enable_bit ##1 (cpuClkEn || state != S_RUN))
    else $error("interrupt did not end doze");

  mod_delay_a: assert property ( // [R19]
    sysClkRun && $past(sysClkRun) && $changed(modDis)
      |-> $stable(periphClkEn)
      ##1 (periphClkEn == ~$past(modDis) || !sysClkRun))
    else $error("module clock change not delayed");

endmodule

`default_nettype wire

// ==== rtl/clk_pwr_pkg.sv ====
/*
  constants and types for the power-save and clock gating block.
  assumes a 20 MHz core clock and an APB register port.
*/
package clk_pwr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CLOCK_DIVISOR_REGISTER_OFF = 8'h00;
  localparam logic [7:0] AUXCFG_OFF = 8'h04;
  localparam logic [7:0] MODDIS_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int RECOVER_BIT  = 15;
  localparam int RATIO_HI     = 14;
  localparam int RATIO_LO     = 12;
  localparam int DOZE_ENABLE_BIT_BIT    = 11;
  localparam int AUX_REF_BIT  = 0;
  localparam int AUX_PLL_BIT  = 1;
  localparam int NUM_MODULES  = 8;
  localparam logic [15:0] CLOCK_DIVISOR_REGISTER_RST = 16'h0000;
  localparam logic [1:0]  AUXCFG_RST = 2'h0;
  localparam logic [7:0]  MODDIS_RST = 8'h00;

  // ---------------------------------------------------------------
  // clock figures
  // ---------------------------------------------------------------
  localparam logic [7:0]  AUX_MULT          = 8'h10;
  localparam logic [13:0] PWM_RES_FINE_PS   = 14'h410;
  localparam logic [13:0] PWM_RES_COARSE_PS = 14'h1F40;
  localparam int CORE_CLK_HZ  = 20000000;
  localparam int INSTR_CYCLES = 1;
  localparam logic [2:0] WAKE_CYCLES = 3'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       recover;
    logic [2:0] ratio;
    logic       doze_enable_bit;
  } clock_divisor_register_t;

  typedef struct packed {
    logic pllSel;
    logic refFastRc;
  } auxcfg_t;

endpackage

// ==== sim/cpu_core_model.sv ====
/*
  cpu core model facing the power-save block.
  assumes one core_clk domain and an active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // bench control
  input  wire logic        saveGo,
  input  wire logic        sleepSel,
  // power-save block side
  input  wire logic        cpuClkEn,
  input  wire logic        cpuExecEn,
  output logic             pwrSaveReq,
  output logic             pwrSaveSleep,
  output logic [15:0]      ticks
);
  // ---------------------------------------------------------------
  // instruction issue and clock tick count
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrSaveReq   <= 1'b0;
      pwrSaveSleep <= 1'b0;
      ticks        <= 16'h0000;
    end else begin
      pwrSaveReq   <= saveGo & cpuExecEn;
      pwrSaveSleep <= sleepSel;
      if (cpuClkEn) ticks <= ticks + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ==== sim/power_save_clock_gating_tb.sv ====
/*
  self-checking bench for the power-save and clock gating block.
  assumes the package constants and zero-wait apb answers.
*/
`timescale 1ns/1ps
`default_nettype none

module power_save_clock_gating_tb;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h00000000;
  logic        saveGo   = 1'b0;
  logic        sleepSel = 1'b0;
  logic        irqPending = 1'b0;
  logic        wdtEnable  = 1'b0;
  logic        clkMonEnable = 1'b0;
  logic        wdtTimeout = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, slv, pwrSaveReq, pwrSaveSleep;
  logic        cpuClkEn, cpuExecEn, resumeIsr, wdtClear, sysClkRun;
  logic        lowPowerRcRun, auxRefFastRc, auxPllSel;
  logic [7:0]  periphClkEn, auxMult;
  logic [13:0] pwmResPs;
  logic [15:0] ticks, t0, dt;
  int          errors = 0, checks = 0, cycles = 0, clears = 0;

  // ---------------------------------------------------------------
  // clock, cycle ceiling, instances
  // ---------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wdtClear === 1'b1) clears <= clears + 1;
    if (cycles == 10000) begin
      errors = errors + 1;
      final_report();
    end
  end

  power_save_clock_gating dut (.core_clk(core_clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwrSaveReq(pwrSaveReq), .pwrSaveSleep(pwrSaveSleep),
    .irqPending(irqPending), .cpuClkEn(cpuClkEn), .cpuExecEn(cpuExecEn),
    .resumeIsr(resumeIsr), .wdtEnable(wdtEnable),
    .clkMonEnable(clkMonEnable), .wdtTimeout(wdtTimeout),
    .wdtClear(wdtClear), .sysClkRun(sysClkRun),
    .lowPowerRcRun(lowPowerRcRun), .periphClkEn(periphClkEn),
    .auxRefFastRc(auxRefFastRc), .auxPllSel(auxPllSel), .auxMult(auxMult),
    .pwmResPs(pwmResPs));

  cpu_core_model cpu (.core_clk(core_clk), .rst_n(rst_n), .saveGo(saveGo),
    .sleepSel(sleepSel), .cpuClkEn(cpuClkEn), .cpuExecEn(cpuExecEn),
    .pwrSaveReq(pwrSaveReq), .pwrSaveSleep(pwrSaveSleep), .ticks(ticks));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    @(negedge core_clk);
    chk(periphClkEn, 8'hFF);
    chk(auxMult, clk_pwr_pkg::AUX_MULT);
    chk(pwmResPs, clk_pwr_pkg::PWM_RES_COARSE_PS);
    chk(lowPowerRcRun, 1'b0);
    @(posedge core_clk);
    clkMonEnable <= 1'b1;
    @(negedge core_clk);
    chk(lowPowerRcRun, 1'b1);
    @(posedge core_clk);
    clkMonEnable <= 1'b0;
    apb(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_OFF, 1'b0, 32'h0);
    chk(rd, 32'(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_RST));
    apb(8'h10, 1'b0, 32'h0);
    chk({31'h0, slv}, 32'h1);
    chk(rd, 32'h0);
    apb(clk_pwr_pkg::STATUS_OFF, 1'b1, 32'h0);
    apb(clk_pwr_pkg::STATUS_OFF, 1'b0, 32'h0);
    chk(rd, 32'h1);
  endtask

  task automatic t_aux(input logic [1:0] v);
    apb(clk_pwr_pkg::AUXCFG_OFF, 1'b1, 32'(v));
    @(negedge core_clk);
    chk(auxRefFastRc, v[0]);
    chk(auxPllSel, v[1]);
    chk(pwmResPs, v[1] ? 14'h410 : 14'h1F40);
    chk(auxMult, 8'h10);
    @(posedge core_clk);
    apb(clk_pwr_pkg::AUXCFG_OFF, 1'b0, 32'h0);
    chk(rd, 32'(v));
    apb(clk_pwr_pkg::STATUS_OFF, 1'b0, 32'h0);
    chk(rd, v[1] ? 32'h11 : 32'h01);
  endtask

  task automatic t_save(input logic sleep, input logic byWdt, input logic early);
    int i, k, c;
    i = 0;
    k = 0;
    c = clears;
    saveGo <= 1'b1;
    sleepSel <= sleep;
    wdtEnable <= 1'b1;
    @(posedge core_clk);
    saveGo <= 1'b0;
    irqPending <= early;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({cpuClkEn, cpuExecEn}, 2'b00);
    chk({sysClkRun, lowPowerRcRun}, {~sleep, 1'b1});
    chk(periphClkEn, sleep ? 8'h00 : 8'hFF);
    @(posedge core_clk);
    if (!early) begin
      irqPending <= ~byWdt;
      wdtTimeout <= byWdt;
    end
    @(negedge core_clk);
    while (cpuClkEn !== 1'b1 && i < 20) begin
      i++;
      @(negedge core_clk);
    end
    while (cpuExecEn !== 1'b1 && k < 20) begin
      k++;
      @(negedge core_clk);
    end
    chk(k, clk_pwr_pkg::WAKE_CYCLES);
    chk(resumeIsr, !byWdt);
    chk(clears - c, sleep ? 0 : 1);
    @(posedge core_clk);
    irqPending <= 1'b0;
    wdtTimeout <= 1'b0;
    wdtEnable <= 1'b0;
  endtask

  task automatic t_doze(input logic [31:0] v, input logic [15:0] exp);
    apb(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_OFF, 1'b1, v);
    @(posedge core_clk);
    t0 = ticks;
    repeat (256) @(posedge core_clk);
    dt = ticks - t0;
    chk(dt, exp);
    chk({sysClkRun, periphClkEn}, 9'h1FF);
  endtask

  task automatic t_roi(input logic [31:0] v, input logic [31:0] exp);
    apb(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_OFF, 1'b1, v);
    irqPending <= 1'b1;
    repeat (2) @(posedge core_clk);
    irqPending <= 1'b0;
    apb(clk_pwr_pkg::CLOCK_DIVISOR_REGISTER_OFF, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic t_moddis(input logic [7:0] v, input logic [7:0] was);
    fork
      apb(clk_pwr_pkg::MODDIS_OFF, 1'b1, 32'(v));
      begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(periphClkEn, was);
        @(negedge core_clk);
        chk(periphClkEn, 8'(~v));
      end
    join
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_aux(2'h3);
    t_aux(2'h1);
    t_aux(2'h0);
    t_save(1'b0, 1'b0, 1'b0);
    t_save(1'b0, 1'b1, 1'b0);
    t_save(1'b0, 1'b0, 1'b1);
    t_save(1'b1, 1'b0, 1'b0);
    for (int r = 0; r < 8; r++) t_doze(32'(r) << 12 | 32'h800, 16'h100 >> r);
    t_doze(32'h7000, 16'h0100);
    t_roi(32'hB800, 32'hB000);
    t_roi(32'h3800, 32'h3800);
    t_moddis(8'h5A, 8'hFF);
    t_moddis(8'h00, 8'hA5);
    final_report();
  end
endmodule

`default_nettype wire
